// ==== core/exec_consts.svh ====
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH
// ****************************************
// timing
// ****************************************
`define CLK_PER_ICYCLE 4
`define SYS_CLK_PERIOD_NS 40
// ****************************************
// opcode fields of the decoded instruction word
// ****************************************
`define OPC_HI 15
`define OPC_LO 11
`define BIT_HI 10
`define BIT_LO 8
`define OPERAND_HI 7
`define OPERAND_LO 0
// ****************************************
// reset values, program counter low byte address and return stack depth
// ****************************************
`define PC_RESET 11'h000
`define ACC_RESET 8'h00
`define PCL_ADDR 8'h02
`define STACK_DEPTH 6
`endif

// ==== core/exec_pkg.sv ====
package exec_pkg;
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_MOV_M_TO_A = 5'h01,
		OP_MOV_A_TO_M = 5'h02,
		OP_MOV_K_TO_A = 5'h03,
		OP_ADD = 5'h04,
		OP_ADC = 5'h05,
		OP_SUB = 5'h06,
		OP_SBC = 5'h07,
		OP_INC_M = 5'h08,
		OP_INC_A = 5'h09,
		OP_DEC_M = 5'h0A,
		OP_DEC_A = 5'h0B,
		OP_AND = 5'h0C,
		OP_OR = 5'h0D,
		OP_XOR = 5'h0E,
		OP_CPL_M = 5'h0F,
		OP_RR = 5'h10,
		OP_RL = 5'h11,
		OP_RRC = 5'h12,
		OP_RLC = 5'h13,
		OP_JMP = 5'h14,
		OP_CALL = 5'h15,
		OP_RET = 5'h16,
		OP_INTERRUPT_EXIT = 5'h17,
		OP_SZ = 5'h18,
		OP_SNZ_BIT = 5'h19,
		OP_SZ_BIT = 5'h1A,
		OP_SET_BIT = 5'h1B,
		OP_CLR_BIT = 5'h1C,
		OP_TABRD = 5'h1D,
		OP_ADD_K = 5'h1E,
		OP_SUB_K = 5'h1F
	} opcode_t;
	typedef enum logic [1:0] {
		ST_EXEC = 2'b00,
		ST_FLUSH = 2'b01
	} exec_state_t;
endpackage : exec_pkg

// ==== core/ret_stack_if.sv ====
`timescale 1ns/10ps
interface ret_stack_if #(parameter int AW = 11);
	logic push;
	logic pop;
	logic [AW-1:0] push_addr;
	logic [AW-1:0] top_addr;
	modport core (output push, output pop, output push_addr, input top_addr);
	modport stack (input push, input pop, input push_addr, output top_addr);
endinterface : ret_stack_if

// ==== core/ret_stack.sv ====
`timescale 1ns/10ps
`include "exec_consts.svh"
module ret_stack #(
	parameter int AW = 11,
	parameter int DEPTH = `STACK_DEPTH
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	ret_stack_if.stack port // push / pop port
);
	// ****************************************
	// circular return address memory
	// ****************************************
	localparam int SPW = $clog2(DEPTH);
	localparam logic [SPW-1:0] SP_LAST = SPW'(DEPTH - 1);
	logic [AW-1:0] mem_q [DEPTH];
	logic [SPW-1:0] sp_q;
	logic [SPW-1:0] sp_dn;
	logic [SPW-1:0] sp_dn2;
	logic [AW-1:0] top_q;
	// sp_dn is the newest entry, sp_dn2 the one that becomes top after a pop
	assign sp_dn = (sp_q == '0) ? SP_LAST : sp_q - SPW'(1);
	assign sp_dn2 = (sp_dn == '0) ? SP_LAST : sp_dn - SPW'(1);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sp_q <= '0;
		end else if (port.push) begin
			sp_q <= (sp_q == SP_LAST) ? '0 : sp_q + SPW'(1);
		end else if (port.pop) begin
			sp_q <= sp_dn;
		end
	end
	always_ff @(posedge clk) begin
		if (port.push) begin
			mem_q[sp_q] <= port.push_addr;
		end
	end
	// registered top of stack, kept current after each push or pop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			top_q <= '0;
		end else if (port.push) begin
			top_q <= port.push_addr;
		end else if (port.pop) begin
			top_q <= mem_q[sp_dn2];
		end
	end
	assign port.top_addr = top_q;
endmodule : ret_stack

// ==== core/instr_exec.sv ====
`timescale 1ns/10ps
`include "exec_consts.svh"
// Overview of operation
// - one instruction cycle is four system clocks
// - most instructions take one cycle; branch, call, table read take two
// - jump, call, return, interrupt return and table read add one cycle
// - writing the program counter low byte jumps and adds one cycle
// - a taken skip adds one cycle; untaken skip takes one
// - moves: memory to accumulator, accumulator to memory, constant to accumulator
// - add sets carry above 255; subtract flags borrow below 0
// - increment and decrement by one, result to memory or accumulator
// - logical and complement results of zero set the zero flag
// - logical operations take the accumulator as one operand
// - rotates move one bit; through-carry rotates pass the bit via carry
// - call saves next address; return resumes there
// - jump loads target and saves no return address
// - conditional skip tests memory value or bit, skips next if met
// - bit set and clear change only the addressed bit
// - add with carry includes current carry
// - table read fetches fixed data from program memory
module instr_exec #(
	parameter int AW = 11
) (
	input wire logic SYS_CLK, // system clock, 25 MHz
	input wire logic SYS_RST, // async reset, active high
	output logic [AW-1:0] PROG_ADDR, // program memory address
	input wire logic [15:0] PROG_DATA, // instruction word, returned for PROG_ADDR
	output logic [AW-1:0] TABLE_ADDR, // table address in program memory
	input wire logic [15:0] TABLE_DATA, // table word for TABLE_ADDR
	output logic [7:0] MEM_ADDR, // data memory address
	input wire logic [7:0] MEM_RDATA, // data memory read data for MEM_ADDR
	output logic [7:0] MEM_WDATA, // data memory write data
	output logic MEM_WE, // data memory write strobe, one system clock
	output logic [7:0] ACC, // accumulator
	output logic CARRY, // carry / not-borrow flag
	output logic ZERO, // zero flag
	output logic INSTR_DONE // pulse at end of each instruction cycle
);
	import exec_pkg::*;
	// ****************************************
	// instruction cycle phase
	// ****************************************
	logic [1:0] phase_q;
	logic last_phase;
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end
	assign last_phase = (phase_q == 2'(`CLK_PER_ICYCLE - 1));
	// ****************************************
	// decode
	// ****************************************
	opcode_t op;
	logic [2:0] bsel;
	logic [7:0] opnd;
	exec_state_t state_q;
	logic [AW-1:0] pc_q;
	logic [7:0] acc_q;
	logic c_q;
	logic z_q;
	logic [7:0] res;
	logic res_c;
	logic wr_acc;
	logic wr_mem;
	logic set_c;
	logic set_z;
	logic redirect;
	logic [AW-1:0] target;
	logic [AW-1:0] pc_next;
	ret_stack_if #(.AW(AW)) rs ();
	assign op = opcode_t'(PROG_DATA[`OPC_HI:`OPC_LO]);
	assign bsel = PROG_DATA[`BIT_HI:`BIT_LO];
	assign opnd = PROG_DATA[`OPERAND_HI:`OPERAND_LO];
	assign pc_next = pc_q + AW'(1);
	always_comb begin
		res = acc_q;
		res_c = c_q;
		wr_acc = 1'b0;
		wr_mem = 1'b0;
		set_c = 1'b0;
		set_z = 1'b0;
		redirect = 1'b0;
		target = pc_next;
		case (op)
			OP_MOV_M_TO_A: begin
				res = MEM_RDATA;
				wr_acc = 1'b1;
			end
			OP_MOV_A_TO_M: begin
				res = acc_q;
				wr_mem = 1'b1;
			end
			OP_MOV_K_TO_A: begin
				res = opnd;
				wr_acc = 1'b1;
			end
			OP_ADD, OP_ADC, OP_ADD_K: begin
				{res_c, res} = {1'b0, acc_q} + {1'b0, (op == OP_ADD_K) ? opnd : MEM_RDATA}
					+ 9'((op == OP_ADC) & c_q);
				wr_acc = 1'b1;
				set_c = 1'b1;
				set_z = 1'b1;
			end
			OP_SUB, OP_SBC, OP_SUB_K: begin
				// carry set means no borrow
				{res_c, res} = {1'b1, acc_q} - {1'b0, (op == OP_SUB_K) ? opnd : MEM_RDATA}
					- 9'((op == OP_SBC) & ~c_q);
				wr_acc = 1'b1;
				set_c = 1'b1;
				set_z = 1'b1;
			end
			OP_INC_M, OP_INC_A, OP_DEC_M, OP_DEC_A: begin
				res = (op == OP_INC_M || op == OP_INC_A) ? MEM_RDATA + 8'h01 : MEM_RDATA - 8'h01;
				wr_mem = (op == OP_INC_M || op == OP_DEC_M);
				wr_acc = ~wr_mem;
				set_z = 1'b1;
			end
			OP_AND, OP_OR, OP_XOR: begin
				case (op)
					OP_AND: res = acc_q & MEM_RDATA;
					OP_OR: res = acc_q | MEM_RDATA;
					default: res = acc_q ^ MEM_RDATA;
				endcase
				wr_acc = 1'b1;
				set_z = 1'b1;
			end
			OP_CPL_M: begin
				res = ~MEM_RDATA;
				wr_mem = 1'b1;
				set_z = 1'b1;
			end
			OP_RR: begin
				res = {MEM_RDATA[0], MEM_RDATA[7:1]};
				wr_mem = 1'b1;
			end
			OP_RL: begin
				res = {MEM_RDATA[6:0], MEM_RDATA[7]};
				wr_mem = 1'b1;
			end
			OP_RRC: begin
				{res, res_c} = {c_q, MEM_RDATA};
				wr_mem = 1'b1;
				set_c = 1'b1;
			end
			OP_RLC: begin
				{res_c, res} = {MEM_RDATA, c_q};
				wr_mem = 1'b1;
				set_c = 1'b1;
			end
			OP_JMP, OP_CALL: begin
				target = AW'({bsel, opnd});
				redirect = 1'b1;
			end
			OP_RET, OP_INTERRUPT_EXIT: begin
				target = rs.top_addr;
				redirect = 1'b1;
			end
			OP_SZ: begin
				target = pc_next + AW'(1);
				redirect = (MEM_RDATA == 8'h00);
			end
			OP_SZ_BIT, OP_SNZ_BIT: begin
				target = pc_next + AW'(1);
				redirect = MEM_RDATA[bsel] ^ (op == OP_SZ_BIT);
			end
			OP_SET_BIT, OP_CLR_BIT: begin
				res = MEM_RDATA;
				res[bsel] = (op == OP_SET_BIT);
				wr_mem = 1'b1;
			end
			OP_TABRD: begin
				res = TABLE_DATA[7:0];
				wr_mem = 1'b1;
				redirect = 1'b1;
			end
			default: begin
			end
		endcase
		if (wr_mem && opnd == `PCL_ADDR) begin
			target = {pc_q[AW-1:8], res};
			redirect = 1'b1;
		end
	end
	// ****************************************
	// sequencing and state
	// ****************************************
	logic exec_now;
	assign exec_now = last_phase && (state_q == ST_EXEC);
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_q <= ST_EXEC;
		end else if (last_phase) begin
			// fetched word is discarded for one cycle after a redirect
			state_q <= (state_q == ST_EXEC && redirect) ? ST_FLUSH : ST_EXEC;
		end
	end
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pc_q <= `PC_RESET;
		end else if (exec_now) begin
			pc_q <= redirect ? target : pc_next;
		end
	end
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			acc_q <= `ACC_RESET;
		end else if (exec_now && wr_acc) begin
			acc_q <= res;
		end
	end
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			c_q <= 1'b0;
			z_q <= 1'b0;
		end else if (exec_now) begin
			if (set_c) begin
				c_q <= res_c;
			end
			if (set_z) begin
				z_q <= (res == 8'h00);
			end
		end
	end
	assign rs.push = exec_now && (op == OP_CALL);
	assign rs.pop = exec_now && (op == OP_RET || op == OP_INTERRUPT_EXIT);
	assign rs.push_addr = pc_next;
	ret_stack #(.AW(AW), .DEPTH(`STACK_DEPTH)) u_stack (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.port(rs.stack)
	);
	assign PROG_ADDR = pc_q;
	assign TABLE_ADDR = AW'({acc_q});
	assign MEM_ADDR = opnd;
	assign MEM_WDATA = res;
	assign MEM_WE = exec_now && wr_mem;
	assign ACC = acc_q;
	assign CARRY = c_q;
	assign ZERO = z_q;
	assign INSTR_DONE = last_phase;
	// ****************************************
	// checks
	// ****************************************
	property p_cycle4;
		@(posedge SYS_CLK) disable iff (SYS_RST) last_phase |=> !last_phase [*3] ##1 last_phase;
	endproperty
	a_cycle4: assert property (p_cycle4) else $error("cycle not four clocks");
	property p_flush;
		@(posedge SYS_CLK) disable iff (SYS_RST) (exec_now && redirect) |=> (state_q == ST_FLUSH) [*4] ##1 state_q == ST_EXEC;
	endproperty
	a_flush: assert property (p_flush) else $error("redirect not one extra cycle");
	property p_single;
		@(posedge SYS_CLK) disable iff (SYS_RST) (exec_now && !redirect) |=> pc_q == $past(pc_q) + AW'(1);
	endproperty
	a_single: assert property (p_single) else $error("plain instruction pc wrong");
	property p_jmp;
		@(posedge SYS_CLK) disable iff (SYS_RST) (exec_now && op == OP_JMP) |=> pc_q == $past(target) && !$past(rs.push);
	endproperty
	a_jmp: assert property (p_jmp) else $error("jump wrong");
	property p_skip;
		@(posedge SYS_CLK) disable iff (SYS_RST) (exec_now && op == OP_SZ && MEM_RDATA == 8'h00) |=> pc_q == $past(pc_q) + AW'(2);
	endproperty
	a_skip: assert property (p_skip) else $error("skip wrong");
	property p_zero;
		@(posedge SYS_CLK) disable iff (SYS_RST) (exec_now && (op == OP_AND || op == OP_XOR)) |=> ZERO == ($past(res) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_add;
		@(posedge SYS_CLK) disable iff (SYS_RST) (exec_now && op == OP_ADD) |=> {CARRY, ACC} == {1'b0, $past(acc_q)} + {1'b0, $past(MEM_RDATA)};
	endproperty
	a_add: assert property (p_add) else $error("add wrong");
	property p_bit;
		@(posedge SYS_CLK) disable iff (SYS_RST) (MEM_WE && op == OP_SET_BIT) |-> (MEM_WDATA | (8'h01 << bsel)) == (MEM_RDATA | (8'h01 << bsel)) && MEM_WDATA[bsel];
	endproperty
	a_bit: assert property (p_bit) else $error("bit set wrong");
	property p_ret;
		@(posedge SYS_CLK) disable iff (SYS_RST) (exec_now && op == OP_RET) |=> pc_q == $past(rs.top_addr);
	endproperty
	a_ret: assert property (p_ret) else $error("return wrong");
	c_call: cover property (@(posedge SYS_CLK) exec_now && op == OP_CALL);
	c_ret: cover property (@(posedge SYS_CLK) exec_now && op == OP_RET);
	c_skip: cover property (@(posedge SYS_CLK) exec_now && op == OP_SZ_BIT && redirect);
	c_pcl: cover property (@(posedge SYS_CLK) MEM_WE && opnd == `PCL_ADDR);
endmodule : instr_exec

// ==== bench/instr_exec_tb.sv ====
`timescale 1ns/10ps
module instr_exec_tb;
	import exec_pkg::*;
	logic SYS_CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic [10:0] PROG_ADDR;
	logic [10:0] TABLE_ADDR;
	logic [15:0] PROG_DATA;
	logic [15:0] TABLE_DATA;
	logic [7:0] MEM_ADDR;
	logic [7:0] MEM_RDATA;
	logic [7:0] MEM_WDATA;
	logic [7:0] ACC;
	logic MEM_WE;
	logic CARRY;
	logic ZERO;
	logic INSTR_DONE;
	logic [15:0] rom [0:31];
	logic [7:0] dm [0:255];
	int err_total = 0;
	int n_checks = 0;
	// ****
	// memories around the core
	// ****
	assign PROG_DATA = rom[PROG_ADDR[4:0]];
	assign MEM_RDATA = dm[MEM_ADDR];
	assign TABLE_DATA = {8'h00, ~TABLE_ADDR[7:0]};
	always @(posedge SYS_CLK) begin
		if (MEM_WE === 1'b1)
			dm[MEM_ADDR] <= MEM_WDATA;
	end
	initial begin
		forever #20 SYS_CLK = ~SYS_CLK;
	end
	instr_exec #(.AW(11)) u_dut (
		.SYS_CLK(SYS_CLK),
		.SYS_RST(SYS_RST),
		.PROG_ADDR(PROG_ADDR),
		.PROG_DATA(PROG_DATA),
		.TABLE_ADDR(TABLE_ADDR),
		.TABLE_DATA(TABLE_DATA),
		.MEM_ADDR(MEM_ADDR),
		.MEM_RDATA(MEM_RDATA),
		.MEM_WDATA(MEM_WDATA),
		.MEM_WE(MEM_WE),
		.ACC(ACC),
		.CARRY(CARRY),
		.ZERO(ZERO),
		.INSTR_DONE(INSTR_DONE)
	);
	// ****
	// helpers
	// ****
	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic put(input int a, input opcode_t o, input logic [10:0] f);
		rom[a] = {o, f};
	endtask : put
	task automatic hold;
		SYS_RST = 1'b1;
		foreach (rom[i])
			rom[i] = 16'h0000;
	endtask : hold
	task automatic go;
		repeat (6) @(posedge SYS_CLK);
		#1;
		SYS_RST = 1'b0;
	endtask : go
	// counts instruction cycles and clocks until the program counter reaches t
	task automatic run_to(input logic [10:0] t, input int cyc);
		int n = 0;
		int c = 0;
		while (PROG_ADDR !== t) begin
			if (c >= 200) begin
				err_total++;
				$display("ERROR timeout waiting for address %h", t);
				finish_test;
			end
			if (INSTR_DONE === 1'b1)
				n++;
			@(posedge SYS_CLK);
			#1;
			c++;
		end
		chk("cycles", 16'(n), 16'(cyc));
		chk("clocks", 16'(c), 16'(4 * cyc));
	endtask : run_to
	// ****
	// scenarios
	// ****
	task automatic t_jump;
		hold;
		put(1, OP_MOV_K_TO_A, 11'h05A);
		put(2, OP_JMP, 11'h008);
		put(3, OP_MOV_K_TO_A, 11'h0EE);
		put(8, OP_ADD_K, 11'h001);
		put(9, OP_JMP, 11'h009);
		go;
		run_to(11'h008, 3);
		run_to(11'h009, 2);
		chk("acc_jump", 16'(ACC), 16'h005B);
	endtask : t_jump
	task automatic t_call;
		hold;
		dm[8'h41] = 8'h77;
		put(0, OP_CALL, 11'h005);
		put(1, OP_ADD_K, 11'h001);
		put(2, OP_JMP, 11'h002);
		put(5, OP_MOV_K_TO_A, 11'h011);
		put(6, OP_MOV_A_TO_M, 11'h040);
		put(7, OP_MOV_M_TO_A, 11'h041);
		put(8, OP_RET, 11'h000);
		go;
		run_to(11'h005, 1);
		run_to(11'h001, 5);
		run_to(11'h002, 2);
		chk("acc_call", 16'(ACC), 16'h0078);
		chk("mem_40", 16'(dm[8'h40]), 16'h0011);
	endtask : t_call
	task automatic t_arith;
		hold;
		dm[8'h50] = 8'h00;
		dm[8'h51] = 8'h07;
		put(0, OP_MOV_K_TO_A, 11'h0FF);
		put(1, OP_ADD_K, 11'h001);
		put(2, OP_ADC, 11'h050);
		put(3, OP_SUB_K, 11'h002);
		put(4, OP_INC_A, 11'h051);
		put(5, OP_DEC_M, 11'h051);
		put(6, OP_JMP, 11'h006);
		go;
		run_to(11'h002, 2);
		chk("acc_add", 16'(ACC), 16'h0000);
		chk("carry_add", 16'(CARRY), 16'h0001);
		run_to(11'h003, 1);
		chk("acc_adc", 16'(ACC), 16'h0001);
		run_to(11'h004, 1);
		chk("acc_sub", 16'(ACC), 16'h00FF);
		chk("carry_sub", 16'(CARRY), 16'h0000);
		run_to(11'h006, 2);
		chk("acc_inc", 16'(ACC), 16'h0008);
		chk("mem_dec", 16'(dm[8'h51]), 16'h0006);
	endtask : t_arith
	task automatic t_logic;
		hold;
		dm[8'h60] = 8'h0F;
		dm[8'h61] = 8'hFF;
		dm[8'h62] = 8'h01;
		dm[8'h63] = 8'h01;
		dm[8'h64] = 8'h01;
		dm[8'h65] = 8'h80;
		put(0, OP_MOV_K_TO_A, 11'h0F0);
		put(1, OP_AND, 11'h060);
		put(2, OP_OR, 11'h060);
		put(3, OP_CPL_M, 11'h061);
		put(4, OP_XOR, 11'h060);
		put(5, OP_MOV_K_TO_A, 11'h0FF);
		put(6, OP_ADD_K, 11'h001);
		put(7, OP_RLC, 11'h062);
		put(8, OP_RRC, 11'h063);
		put(9, OP_RR, 11'h064);
		put(10, OP_RL, 11'h065);
		put(11, OP_JMP, 11'h00B);
		go;
		run_to(11'h002, 2);
		chk("acc_and", 16'(ACC), 16'h0000);
		chk("zero_and", 16'(ZERO), 16'h0001);
		run_to(11'h003, 1);
		chk("acc_or", 16'(ACC), 16'h000F);
		chk("zero_or", 16'(ZERO), 16'h0000);
		run_to(11'h004, 1);
		chk("mem_cpl", 16'(dm[8'h61]), 16'h0000);
		chk("zero_cpl", 16'(ZERO), 16'h0001);
		run_to(11'h009, 5);
		chk("mem_rlc", 16'(dm[8'h62]), 16'h0003);
		chk("mem_rrc", 16'(dm[8'h63]), 16'h0000);
		chk("carry_rrc", 16'(CARRY), 16'h0001);
		run_to(11'h00B, 2);
		chk("mem_rr", 16'(dm[8'h64]), 16'h0080);
		chk("mem_rl", 16'(dm[8'h65]), 16'h0001);
	endtask : t_logic
	task automatic t_skip;
		hold;
		dm[8'h20] = 8'h00;
		dm[8'h21] = 8'hFF;
		put(0, OP_SET_BIT, 11'h320);
		put(1, OP_CLR_BIT, 11'h021);
		put(2, OP_SNZ_BIT, 11'h320);
		put(3, OP_MOV_K_TO_A, 11'h0EE);
		put(4, OP_SZ, 11'h021);
		put(5, OP_SZ_BIT, 11'h021);
		put(6, OP_MOV_K_TO_A, 11'h0EE);
		put(7, OP_MOV_K_TO_A, 11'h042);
		put(8, OP_JMP, 11'h008);
		go;
		run_to(11'h002, 2);
		chk("mem_set", 16'(dm[8'h20]), 16'h0008);
		chk("mem_clr", 16'(dm[8'h21]), 16'h00FE);
		run_to(11'h004, 1);
		run_to(11'h005, 2);
		run_to(11'h007, 1);
		run_to(11'h008, 2);
		chk("acc_skip", 16'(ACC), 16'h0042);
	endtask : t_skip
	task automatic t_pcl;
		hold;
		put(0, OP_MOV_K_TO_A, 11'h009);
		put(1, OP_MOV_A_TO_M, 11'h002);
		put(2, OP_MOV_K_TO_A, 11'h0EE);
		put(9, OP_TABRD, 11'h030);
		put(10, OP_MOV_A_TO_M, 11'h031);
		put(11, OP_JMP, 11'h00B);
		go;
		run_to(11'h009, 2);
		run_to(11'h00A, 2);
		run_to(11'h00B, 2);
		chk("acc_pcl", 16'(ACC), 16'h0009);
		chk("mem_31", 16'(dm[8'h31]), 16'h0009);
		chk("mem_table", 16'(dm[8'h30]), 16'h00F6);
	endtask : t_pcl
	initial begin
		t_jump;
		t_call;
		t_arith;
		t_logic;
		t_skip;
		t_pcl;
		finish_test;
	end
endmodule : instr_exec_tb
